// ### verilog/motor_speed_control_io.v
`include "motor_speed_control_io_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module motor_speed_control_io #(
	parameter TICK_CYCLES = `TICK_CYCLES,
	parameter SETPOINT_TIMEOUT = `SETPOINT_TIMEOUT_CYCLES,
	parameter PWM_PERIOD = `PWM_PERIOD_CYCLES
) (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// Avalon-MM slave
	input wire [4:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output wire waitrequest,
	// Setpoint comparators, direction, Hall sensors
	input wire setpointTtl,
	input wire setpointPlc,
	input wire [9:0] setpointCode,
	input wire direction,
	input wire [2:0] hall,
	// Current controller
	input wire currentLimited,
	// Power stage gates
	output reg [2:0] highSide,
	output reg [2:0] lowSide,
	// Open-collector multipurpose output
	input wire speedPulseOutputIn,
	output wire speedPulseOutput,
	output reg speedPulseOutputOe
);

	// ==========================================
	// Functions
	// Byte-lane merge for register writes
	function [31:0] mergeBytes;
		input [31:0] old;
		input [31:0] data;
		input [3:0] be;
		integer i;
		begin
			mergeBytes = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i])
					mergeBytes[8*i +: 8] = data[8*i +: 8];
			end
		end
	endfunction

	// Hall state to {high[2:0], low[2:0]}; invalid states switch all off
	function [5:0] commutate;
		input [2:0] h;
		input cw;
		reg [5:0] t;
		begin
			case (h)
				3'h5: t = {3'h1, 3'h2};
				3'h4: t = {3'h1, 3'h4};
				3'h6: t = {3'h2, 3'h4};
				3'h2: t = {3'h2, 3'h1};
				3'h3: t = {3'h4, 3'h1};
				3'h1: t = {3'h4, 3'h2};
				default: t = 6'h00;
			endcase
			commutate = cw ? t : {t[2:0], t[5:3]};
		end
	endfunction

	// ==========================================
	// Input synchronisers
	reg [5:0] syncA;
	reg [5:0] syncB;
	reg [2:0] hallPrev;
	reg setPrev;
	// Two stages; only syncB feeds the logic below
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			syncA <= 6'h00;
			syncB <= 6'h00;
		end else begin
			syncA <= {setpointPlc, setpointTtl, direction, hall};
			syncB <= syncA;
		end
	end
	wire [2:0] hallS = syncB[2:0];
	wire dirS = syncB[3];

	// ==========================================
	// Registers
	reg [`CTL_WIDTH-1:0] control;
	reg [15:0] fixedSpeed;
	reg [15:0] fullScale;
	reg [12:0] errorDelay;
	reg ack;
	reg errorFlag;
	reg running;
	reg pwmStopped;
	reg [15:0] speed;
	reg [15:0] target;
	reg [8:0] duty;
	wire [1:0] mode = control[`CTL_MODE];
	wire setS = control[`CTL_PLC_LEVEL] ? syncB[5] : syncB[4];
	wire [31:0] nextWord = mergeBytes(32'h0, writedata, byteenable);
	// Merged words, cut to field width on purpose below
	wire [31:0] mergedCtl = mergeBytes({22'h0, control}, writedata, byteenable);
	wire [31:0] mergedFixed = mergeBytes({16'h0, fixedSpeed}, writedata, byteenable);
	wire [31:0] mergedDelay = mergeBytes({19'h0, errorDelay}, writedata, byteenable);

	// One wait state: answer at the second edge of a request
	assign waitrequest = (read | write) & ~ack;

	// Register writes and read data
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ack <= 1'b0;
			readdata <= 32'h0;
			control <= `RST_CONTROL;
			fixedSpeed <= `RST_FIXED_SPEED;
			fullScale <= `RST_FULL_SCALE;
			errorDelay <= `RST_ERROR_DELAY;
		end else begin
			ack <= (read | write) & ~ack;
			if (read & ~ack) begin
				case (address)
					`OFS_CONTROL: readdata <= {22'h0, control};
					`OFS_FIXED_SPEED: readdata <= {16'h0, fixedSpeed};
					`OFS_FULL_SCALE: readdata <= {16'h0, fullScale};
					`OFS_ERROR_DELAY: readdata <= {19'h0, errorDelay};
					`OFS_STATUS: readdata <= {26'h0, speedPulseOutputIn, pwmStopped,
						dirS, currentLimited, errorFlag, running};
					`OFS_SPEED: readdata <= {16'h0, speed};
					`OFS_TARGET: readdata <= {16'h0, target};
					`OFS_DUTY: readdata <= {23'h0, duty};
					default: readdata <= 32'h0;
				endcase
			end
			if (write & ack) begin
				case (address)
					`OFS_CONTROL:
						control <= mergedCtl[`CTL_WIDTH-1:0];
					`OFS_FIXED_SPEED:
						fixedSpeed <= mergedFixed[15:0];
					`OFS_FULL_SCALE: begin
						// Clamp: larger values would overrun the speed scaling
						if (mergeBytes({16'h0, fullScale}, writedata, byteenable) >
							{16'h0, `FULL_SCALE_CEILING})
							fullScale <= `FULL_SCALE_CEILING;
						else
							fullScale <= nextWord[15:0] | (fullScale & ~{{8{byteenable[1]}},
								{8{byteenable[0]}}});
					end
					`OFS_ERROR_DELAY:
						errorDelay <= mergedDelay[12:0];
					default: ;
				endcase
			end
		end
	end

	// ==========================================
	// Millisecond tick
	reg [15:0] tickCnt;
	wire tick = (tickCnt == TICK_CYCLES - 1);
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			tickCnt <= 16'h0;
		else
			tickCnt <= tick ? 16'h0 : tickCnt + 16'h1;
	end

	// ==========================================
	// Delayed current error flag
	reg [12:0] limitMs;
	// Limit time counted in ms while limiting lasts; flag drops with it
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			limitMs <= 13'h0;
			errorFlag <= 1'b0;
		end else begin
			if (!currentLimited)
				limitMs <= 13'h0;
			else if (tick && limitMs != 13'h1FFF)
				limitMs <= limitMs + 13'h1;
			errorFlag <= currentLimited & (limitMs >= errorDelay);
		end
	end

	// ==========================================
	// Shared sequential divider (32 cycles)
	localparam DIV_IDLE = 2'b01;
	localparam DIV_BUSY = 2'b10;
	reg [1:0] divState;
	reg [32:0] rem;
	reg [31:0] quo;
	reg [31:0] den;
	reg [5:0] bitCnt;
	reg ownerSpeed;
	reg speedReq;
	reg [31:0] speedDen;
	reg setReq;
	reg [31:0] setNum;
	reg [31:0] setDen;
	reg [15:0] pwmTarget;
	reg hallZero;
	wire [32:0] trial = {rem[31:0], quo[31]};

	// ==========================================
	// Hall interval timing and speed pulses
	reg [23:0] edgeCnt;
	reg [23:0] halfCnt;
	reg [2:0] edgeIdx;
	reg [1:0] pulseIdx;
	reg pulseLevel;
	wire hallEdge = (hallS != hallPrev);
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hallPrev <= 3'h0;
			edgeCnt <= 24'h0;
			halfCnt <= 24'h0;
			edgeIdx <= 3'h0;
			pulseIdx <= 2'h0;
			pulseLevel <= 1'b0;
			speedReq <= 1'b0;
			speedDen <= 32'h1;
			hallZero <= 1'b1;
		end else begin
			hallPrev <= hallS;
			if (edgeCnt != `HALL_TIMEOUT_CYCLES)
				edgeCnt <= edgeCnt + 24'h1;
			if (halfCnt != `HALL_TIMEOUT_CYCLES)
				halfCnt <= halfCnt + 24'h1;
			if (edgeCnt == `HALL_TIMEOUT_CYCLES)
				hallZero <= 1'b1;
			if (divState == DIV_IDLE && speedReq)
				speedReq <= 1'b0;
			if (hallEdge) begin
				hallZero <= 1'b0;
				edgeCnt <= 24'h1;
				edgeIdx <= (edgeIdx == 3'h5) ? 3'h0 : edgeIdx + 3'h1;
				// Six edges make one electrical turn, half a mechanical one
				if (!control[`CTL_HALL_FILTER]) begin
					speedReq <= 1'b1;
					speedDen <= {8'h0, edgeCnt};
				end else if (edgeIdx == 3'h5) begin
					speedReq <= 1'b1;
					speedDen <= {8'h0, halfCnt};
					halfCnt <= 24'h1;
				end
				// 12 edges per turn: toggle every 1 edge for 6, every 3 for 2
				if (!control[`CTL_TWO_PULSES] || pulseIdx == 2'h2) begin
					pulseLevel <= ~pulseLevel;
					pulseIdx <= 2'h0;
				end else
					pulseIdx <= pulseIdx + 2'h1;
			end
		end
	end

	// ==========================================
	// PWM setpoint duty measurement
	reg [16:0] highCnt;
	reg [16:0] totalCnt;
	wire [26:0] highPermille = {10'h0, highCnt} * 27'h3E8;
	// Period runs rising edge to rising edge; a timeout counts as stopped
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			setPrev <= 1'b0;
			highCnt <= 17'h0;
			totalCnt <= 17'h0;
			setReq <= 1'b0;
			setNum <= 32'h0;
			setDen <= 32'h1;
			pwmStopped <= 1'b1;
		end else begin
			setPrev <= setS;
			if (divState == DIV_IDLE && !speedReq && setReq)
				setReq <= 1'b0;
			if (setS & ~setPrev) begin
				highCnt <= 17'h1;
				totalCnt <= 17'h1;
				if ({15'h0, totalCnt} < SETPOINT_TIMEOUT) begin
					// Halve only long periods, so short ones keep full precision
					setNum <= totalCnt[16] ? fullScale * highCnt[16:1] :
						fullScale * highCnt[15:0];
					setDen <= totalCnt[16] ? {16'h0, totalCnt[16:1]} :
						{16'h0, totalCnt[15:0]};
					setReq <= 1'b1;
					if (highPermille < totalCnt * `STOP_PERMILLE)
						pwmStopped <= 1'b1;
					else if (highPermille > totalCnt * `RUN_PERMILLE)
						pwmStopped <= 1'b0;
				end
			end else begin
				if ({15'h0, totalCnt} < SETPOINT_TIMEOUT)
					totalCnt <= totalCnt + 17'h1;
				else
					pwmStopped <= 1'b1;
				if (setS && {15'h0, highCnt} < SETPOINT_TIMEOUT)
					highCnt <= highCnt + 17'h1;
			end
		end
	end

	// Divider: speed requests take priority over setpoint requests
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			divState <= DIV_IDLE;
			rem <= 33'h0;
			quo <= 32'h0;
			den <= 32'h1;
			bitCnt <= 6'h0;
			ownerSpeed <= 1'b0;
			speed <= 16'h0;
			pwmTarget <= 16'h0;
		end else begin
			if (hallZero)
				speed <= 16'h0;
			case (divState)
				DIV_IDLE: begin
					rem <= 33'h0;
					bitCnt <= 6'h0;
					if (speedReq) begin
						ownerSpeed <= 1'b1;
						quo <= control[`CTL_HALL_FILTER] ? `SPEED_NUM_HALF : `SPEED_NUM_EDGE;
						den <= speedDen;
						divState <= DIV_BUSY;
					end else if (setReq) begin
						ownerSpeed <= 1'b0;
						quo <= setNum;
						den <= setDen;
						divState <= DIV_BUSY;
					end
				end
				DIV_BUSY: begin
					if (trial >= {1'b0, den}) begin
						rem <= trial - {1'b0, den};
						quo <= {quo[30:0], 1'b1};
					end else begin
						rem <= trial;
						quo <= {quo[30:0], 1'b0};
					end
					bitCnt <= bitCnt + 6'h1;
					if (bitCnt == 6'h1F)
						divState <= DIV_IDLE;
					if (bitCnt == 6'h1F && ownerSpeed && !hallZero)
						speed <= (quo[30:15] != 16'h0) ? 16'hFFFF :
							{quo[14:0], trial >= {1'b0, den}};
					if (bitCnt == 6'h1F && !ownerSpeed)
						pwmTarget <= (quo[30:15] != 16'h0) ? 16'hFFFF :
							{quo[14:0], trial >= {1'b0, den}};
				end
				default: divState <= DIV_IDLE;
			endcase
		end
	end

	// ==========================================
	// Target selection and run decision
	reg nextRunning;
	reg [15:0] nextTarget;
	wire [25:0] analogScaled = fullScale * setpointCode;
	always @* begin
		nextRunning = 1'b1;
		nextTarget = analogScaled[25:10];
		case (mode)
			`MODE_PWM_SET: begin
				nextRunning = ~pwmStopped;
				nextTarget = pwmTarget;
			end
			`MODE_FIXED: begin
				nextTarget = fixedSpeed;
				case (control[`CTL_QSTOP])
					`QSTOP_LOW: nextRunning = setS;
					`QSTOP_HIGH: nextRunning = ~setS;
					default: nextRunning = 1'b1;
				endcase
			end
			default: nextRunning = 1'b1;
		endcase
	end

	// ==========================================
	// Duty regulation
	wire decel = (speed > target);
	wire [18:0] voltDuty = setpointCode * PWM_PERIOD[8:0];
	// Integral-only step per ms: slow but never overshoots the period
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			running <= 1'b0;
			target <= 16'h0;
			duty <= 9'h0;
		end else begin
			running <= nextRunning;
			target <= nextTarget;
			if (!running)
				duty <= 9'h0;
			else if (mode == `MODE_VOLT)
				duty <= voltDuty[18:10];
			else if (tick) begin
				if (speed < target && duty < PWM_PERIOD[8:0])
					duty <= duty + 9'h1;
				else if (decel && duty != 9'h0)
					duty <= duty - 9'h1;
			end
		end
	end

	// ==========================================
	// Power stage PWM and quadrant logic
	reg [8:0] pwmCnt;
	wire [5:0] comm = commutate(hallS, dirS);
	// Current limit chops the on time in every mode, voltage mode included
	wire pwmOn = running & (pwmCnt < duty) & ~currentLimited;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pwmCnt <= 9'h0;
			highSide <= 3'h0;
			lowSide <= 3'h0;
		end else begin
			pwmCnt <= (pwmCnt == PWM_PERIOD[8:0] - 9'h1) ? 9'h0 : pwmCnt + 9'h1;
			if (pwmOn) begin
				highSide <= comm[5:3];
				lowSide <= comm[2:0];
			end else begin
				highSide <= 3'h0;
				// No dead time here: the gate driver must insert it
				if (!running)
					lowSide <= 3'h0;
				else if (control[`CTL_FOUR_QUAD])
					lowSide <= comm[5:3] | comm[2:0];
				else if (decel && !control[`CTL_BRAKE_OFF] && comm != 6'h00)
					lowSide <= 3'h7;
				else
					lowSide <= comm[2:0];
			end
		end
	end

	// ==========================================
	// Multipurpose open-collector output
	// Pin pulled low when the selected level is low
	assign speedPulseOutput = 1'b0;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			speedPulseOutputOe <= 1'b1;
		else if (control[`CTL_ERROR_MODE])
			speedPulseOutputOe <= ~errorFlag;
		else
			speedPulseOutputOe <= ~pulseLevel;
	end

endmodule // motor_speed_control_io
`default_nettype wire

// ### pkg/motor_speed_control_io_defines.vh
`ifndef MOTOR_SPEED_CONTROL_IO_DEFINES_VH
`define MOTOR_SPEED_CONTROL_IO_DEFINES_VH
// ==========================================
// Clock and timing
`define CLOCK_KHZ 25000
`define PWM_KHZ 96
`define PWM_PERIOD_CYCLES (`CLOCK_KHZ / `PWM_KHZ)
`define TICK_MS 1
`define TICK_CYCLES (`CLOCK_KHZ * `TICK_MS)
`define SETPOINT_MIN_HZ 500
`define SETPOINT_MAX_HZ 18000
`define SETPOINT_TIMEOUT_CYCLES (2 * `CLOCK_KHZ * 1000 / `SETPOINT_MIN_HZ)
`define HALL_TIMEOUT_CYCLES 24'hFFFFFF
// Speed numerators: rpm = numerator / interval (12 edges per revolution)
`define SPEED_NUM_EDGE (`CLOCK_KHZ * 1000 * 60 / 12)
`define SPEED_NUM_HALF (`CLOCK_KHZ * 1000 * 60 / 2)
// ==========================================
// Duty thresholds, per mille, and full-scale ceiling
`define STOP_PERMILLE 20
`define RUN_PERMILLE 30
`define PERMILLE_FULL 1000
`define FULL_SCALE_CEILING 16'hEA60
// ==========================================
// Register byte offsets
`define OFS_CONTROL 5'h00
`define OFS_FIXED_SPEED 5'h04
`define OFS_FULL_SCALE 5'h08
`define OFS_ERROR_DELAY 5'h0C
`define OFS_STATUS 5'h10
`define OFS_SPEED 5'h14
`define OFS_TARGET 5'h18
`define OFS_DUTY 5'h1C
// ==========================================
// Control fields
`define CTL_MODE 1:0
`define CTL_QSTOP 3:2
`define CTL_ERROR_MODE 4
`define CTL_TWO_PULSES 5
`define CTL_BRAKE_OFF 6
`define CTL_FOUR_QUAD 7
`define CTL_HALL_FILTER 8
`define CTL_PLC_LEVEL 9
`define CTL_WIDTH 10
`define MODE_ANALOG 2'h0
`define MODE_PWM_SET 2'h1
`define MODE_FIXED 2'h2
`define MODE_VOLT 2'h3
`define QSTOP_NONE 2'h0
`define QSTOP_LOW 2'h1
`define QSTOP_HIGH 2'h2
// ==========================================
// Reset values
`define RST_CONTROL 10'h000
`define RST_FIXED_SPEED 16'h0BB8
`define RST_FULL_SCALE 16'h2710
`define RST_ERROR_DELAY 13'h0000
`endif

// ### dv/motor_speed_control_io_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Bus and output checker
module msc_checker #(
	parameter TICK_CYCLES = 20
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Register bus
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Pins
	input wire logic [2:0] hall,
	input wire logic currentLimited,
	input wire logic [2:0] highSide,
	input wire logic [2:0] lowSide,
	input wire logic speedPulseOutputOe
);
	logic errMode;
	logic [12:0] errDelay;
	logic [31:0] limCount;
	// Shadow of mode and delay; full lanes assumed
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			errMode <= 1'b0;
			errDelay <= 13'h0000;
		end else if (write && !waitrequest) begin
			if (address == 5'h00)
				errMode <= writedata[4];
			if (address == 5'h0C)
				errDelay <= writedata[12:0];
		end
	end
	// Length of the running limit episode
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			limCount <= 32'h0;
		else
			limCount <= currentLimited ? limCount + 32'h1 : 32'h0;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence busAnswer;
		waitrequest ##1 !waitrequest;
	endsequence
	chk_one_wait: assert property ($rose(read || write) |-> busAnswer)
		else $error("no answer after one wait");
	chk_idle_nowait: assert property (!read && !write |-> !waitrequest)
		else $error("wait while idle");
	chk_rdata_stand: assert property (!$past(read) |-> $stable(readdata))
		else $error("read data moved");
	chk_err_clear: assert property (
		(errMode && !currentLimited) [*5] |-> speedPulseOutputOe)
		else $error("error pin not released");
	chk_err_late: assert property (
		errMode && currentLimited
		&& limCount == (errDelay + 1) * TICK_CYCLES + 6 |-> !speedPulseOutputOe)
		else $error("error pin too late");
	chk_err_early: assert property (
		errMode && $fell(speedPulseOutputOe) |-> limCount != 0
		&& (errDelay == 0 || limCount + TICK_CYCLES >= errDelay * TICK_CYCLES))
		else $error("error pin too early");
	chk_lim_gates: assert property (currentLimited [*4] |-> highSide == 3'h0)
		else $error("high side on while limited");
	chk_hall_bad: assert property (
		(hall == 3'h0 || hall == 3'h7) [*4] |-> (highSide | lowSide) == 3'h0)
		else $error("gates on with bad hall");
	chk_no_shoot: assert property ((highSide & lowSide) == 3'h0)
		else $error("phase shorted");
endmodule // msc_checker
`default_nettype wire

// ### dv/ext_controller.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Far-side controller: setpoint source, pulled-up output pin
module ext_controller (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Setpoint shape; period 0 leaves the line open
	input wire logic [15:0] period,
	input wire logic [15:0] highTime,
	// Output pin
	input wire logic pinPullOe,
	output logic pinLevel,
	// Setpoint lines
	output logic setpointTtl,
	output logic setpointPlc
);
	logic [15:0] phase;
	// Phase of the setpoint period
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			phase <= 16'h0000;
		else if (phase + 16'h1 >= period)
			phase <= 16'h0000;
		else
			phase <= phase + 16'h1;
	end
	// Open line reads low; high time at or above period gives a level
	assign setpointTtl = (period != 16'h0000) && (phase < highTime);
	assign setpointPlc = 1'b0;
	// Pull-up wins unless the device sinks the pin
	assign pinLevel = !pinPullOe;
endmodule // ext_controller
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Testbench
module tb;
	logic clock = 1'b0;
	logic rst_b, read, write, direction, currentLimited, setpointTtl, setpointPlc;
	logic waitrequest, speedPulseOutputOe, pinLevel, lastPin;
	logic [4:0] address;
	logic [31:0] writedata, readdata;
	logic [2:0] hall, highSide, lowSide;
	logic [15:0] pwmPeriod, pwmHigh;
	logic [2:0] hallSeq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
	int hallIdx = 5;
	int errCount = 0;
	int nTests = 0;
	int toggles = 0;
	int cycles = 0;
	motor_speed_control_io #(.TICK_CYCLES(20), .SETPOINT_TIMEOUT(4000), .PWM_PERIOD(260)) dut_u (
		.clock(clock), .rst_b(rst_b), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hF), .readdata(readdata),
		.waitrequest(waitrequest), .setpointTtl(setpointTtl), .setpointPlc(setpointPlc),
		.setpointCode(10'h000), .direction(direction), .hall(hall),
		.currentLimited(currentLimited), .highSide(highSide), .lowSide(lowSide),
		.speedPulseOutputIn(pinLevel), .speedPulseOutput(),
		.speedPulseOutputOe(speedPulseOutputOe));
	ext_controller ctl_u (.clock(clock), .rst_b(rst_b), .period(pwmPeriod),
		.highTime(pwmHigh), .pinPullOe(speedPulseOutputOe), .pinLevel(pinLevel),
		.setpointTtl(setpointTtl), .setpointPlc(setpointPlc));
	// Clock and hang guard
	always #20 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 90000) begin
			errCount++;
			reportAndStop();
		end
	end
	// Pin edges for the pulse-rate checks
	always @(posedge clock) begin
		if (pinLevel !== lastPin)
			toggles++;
		lastPin <= pinLevel;
	end
	// ==========
	// Shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			errCount++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge clock);
		address <= a;
		writedata <= wd;
		write <= wr;
		read <= !wr;
		do @(posedge clock); while (waitrequest !== 1'b0);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rdChk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		check(x & m, e);
	endtask
	task automatic hallSteps(input int n, input int t1, input int t2);
		for (int i = 0; i < n; i++) begin
			repeat ((i % 2) ? t2 : t1) @(posedge clock);
			hallIdx = (hallIdx + 1) % 6;
			hall <= hallSeq[hallIdx];
		end
	endtask
	task automatic setPwm(input logic [15:0] p, input logic [15:0] h);
		pwmPeriod <= p;
		pwmHigh <= h;
		repeat (6000) @(posedge clock);
	endtask
	task automatic reportAndStop();
		$display("mismatches %0d of %0d checks", errCount, nTests);
		if (errCount == 0 && nTests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ==========
	// Scenarios
	task automatic testRegs();
		rdChk(5'h00, 32'hFFFFFFFF, 32'h0);
		rdChk(5'h04, 32'hFFFFFFFF, 32'h0BB8);
		rdChk(5'h08, 32'hFFFFFFFF, 32'h2710);
		rdChk(5'h0C, 32'hFFFFFFFF, 32'h0);
		wr(5'h08, 32'hFFFF);
		rdChk(5'h08, 32'hFFFFFFFF, 32'hEA60);
		wr(5'h14, 32'h1234);
		rdChk(5'h14, 32'hFFFFFFFF, 32'h0);
	endtask
	task automatic testFixed();
		logic run;
		for (int q = 0; q < 3; q++) begin
			for (int l = 0; l < 2; l++) begin
				wr(5'h00, 32'h2 | (q << 2));
				pwmPeriod <= 16'(l);
				pwmHigh <= 16'(l);
				direction <= l[0];
				repeat (8) @(posedge clock);
				run = (q == 0) ? 1'b1 : (q == 1) ? l[0] : !l[0];
				rdChk(5'h10, 32'h9, {l[0], 2'b00, run});
				if (run)
					rdChk(5'h18, 32'hFFFF, 32'h0BB8);
			end
		end
	endtask
	task automatic testPulse();
		int base;
		hallSteps(1, 50, 50);
		repeat (8) @(posedge clock);
		base = toggles;
		hallSteps(6, 50, 50);
		repeat (8) @(posedge clock);
		check(toggles - base, 6);
		wr(5'h00, 32'h22);
		base = toggles;
		hallSteps(6, 50, 50);
		repeat (8) @(posedge clock);
		check(toggles - base, 2);
	endtask
	// Uneven intervals tell the filtered value from the plain one
	task automatic testSpeed();
		hallSteps(4, 2500, 2500);
		repeat (200) @(posedge clock);
		rdChk(5'h14, 32'hFFFFFFFF, 32'hC350);
		wr(5'h00, 32'h102);
		hallSteps(8, 2000, 3000);
		repeat (200) @(posedge clock);
		rdChk(5'h14, 32'hFFFFFFFF, 32'hC350);
	endtask
	task automatic testPwm();
		wr(5'h00, 32'h1);
		setPwm(2000, 1000);
		rdChk(5'h10, 32'h11, 32'h1);
		rdChk(5'h18, 32'hFFFF, 32'h7530);
		setPwm(2000, 50);
		rdChk(5'h10, 32'h10, 32'h0);
		setPwm(2000, 20);
		rdChk(5'h10, 32'h10, 32'h10);
		setPwm(2000, 50);
		rdChk(5'h10, 32'h10, 32'h10);
		setPwm(1389, 463);
		rdChk(5'h18, 32'hFFFF, 32'h4E20);
		wr(5'h00, 32'h201);
		repeat (6000) @(posedge clock);
		rdChk(5'h10, 32'h10, 32'h10);
	endtask
	task automatic testError();
		wr(5'h0C, 32'h2);
		wr(5'h00, 32'h13);
		repeat (10) @(posedge clock);
		check(pinLevel, 1'b0);
		currentLimited <= 1'b1;
		repeat (18) @(posedge clock);
		check(pinLevel, 1'b0);
		repeat (70) @(posedge clock);
		check(pinLevel, 1'b1);
		rdChk(5'h10, 32'h6, 32'h6);
		currentLimited <= 1'b0;
		repeat (6) @(posedge clock);
		check(pinLevel, 1'b0);
	endtask
	// Main sequence
	initial begin
		rst_b = 1'b0;
		{read, write, direction, currentLimited} = 4'h0;
		address = 5'h00;
		writedata = 32'h0;
		hall = 3'h0;
		pwmPeriod = 16'h0000;
		pwmHigh = 16'h0000;
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		testRegs();
		testFixed();
		testPulse();
		testSpeed();
		testPwm();
		testError();
		reportAndStop();
	end
endmodule // tb
bind motor_speed_control_io msc_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
	.clock(clock), .rst_b(rst_b), .address(address), .read(read), .write(write),
	.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.hall(hall), .currentLimited(currentLimited), .highSide(highSide),
	.lowSide(lowSide), .speedPulseOutputOe(speedPulseOutputOe));
`default_nettype wire
